// ===== fp_trap_exception_unit.sv
// Purpose : fp trap classification, masking and flag update
// Assumes : op inputs and register port are on sys_clk
// Notes   : one op per cycle, answer one cycle later
//
// Overview of operation
// RULE1: every fault goes to one of three trap vectors
// RULE2: unit off traps to vector 020 hex and sets no flags
// RULE3: unfinished or unimplemented operation takes the incomplete trap
// RULE4: trap type 3 unimplemented, 2 unfinished, 1 ieee, unchanged when off
// RULE5: traps are precise; faulting address is reported to the pipeline
// RULE6: trap leaves destination, condition codes and accrued bits alone
// RULE7: ieee trap sets matching current bit; other traps leave them
// RULE8: priority is unit off, then incomplete, then ieee
// RULE9: each of the five exceptions has its own enable bit
// RULE10: masked exception sets current bits and writes default result
// RULE11: nan source or unfit integer result gives bad operation
// RULE12: overflow also raises inexact
// RULE13: masked valid overflow writes infinity
// RULE14: underflow is judged on the unrounded result
// RULE15: gross underflow gives zero and raises inexact; code raises only underflow when tiny with underflow and inexact both masked
// RULE16: untrapped underflow result is zero, subnormal or least normal
// RULE17: no exponent wrap; trapped keeps registers, untrapped gives default
// RULE18: divide by zero comes only from divide with zero divisor
// RULE19: rounded differs from exact sets inexact current, accrued if untrapped; code sets neither when tiny with underflow and inexact both masked
// RULE20: int to float inexact beyond 23 or 52 fraction bits
// RULE21: underflow enabled traps on tiny; exact tiny only if subnormal
// RULE22: underflow masked and exact tiny sets nothing
// RULE23: masked tiny inexact traps on inexact enable, else sets uf bits
`timescale 1ns/100ps
`include "fp_trap_cfg.svh"

module fp_trap_exception_unit (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  arst_n,
  // register port
  input  wire logic [`ADDR_W-1:0]    reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  // operation from the datapath
  input  wire fp_trap_pkg::op_req_t  op_req,
  // answer to the pipeline
  output fp_trap_pkg::op_rsp_t       op_rsp
);

  // ========================================================
  // reset release
  logic rst_meta_q;
  logic rst_n_q;

  // two flops release the async reset
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ========================================================
  // state
  fp_trap_pkg::state_t s_q;
  fp_trap_pkg::state_t s_d;

  // exception working set
  logic [4:0] exc;
  logic [4:0] hit;
  logic       inexact_raw;
  logic       under_exc;
  logic       inexact_tiny;

  // raw exception detection
  always_comb begin
    inexact_raw  = op_req.inexact | op_req.gross_uf;   // RULE15 RULE19 RULE20
    under_exc    = 1'b0;
    inexact_tiny = 1'b0;
    // tininess from the unrounded result
    if (op_req.tiny) begin                             // RULE14
      if (s_q.trap_mask[`EXC_UNDER]) begin
        under_exc = inexact_raw | op_req.r_subnormal;  // RULE21
      end else if (inexact_raw) begin
        if (s_q.trap_mask[`EXC_INEXACT]) begin
          inexact_tiny = 1'b1;                         // RULE23
        end else begin
          under_exc = 1'b1;                            // RULE23
        end
      end
    end
    exc               = 5'h00;
    exc[`EXC_BADOP]   = op_req.nan_source | op_req.int_no_fit;   // RULE11
    exc[`EXC_OVER]    = op_req.overflow;
    exc[`EXC_UNDER]   = under_exc;
    exc[`EXC_DIVZERO] = op_req.is_divide & op_req.divisor_zero;  // RULE18
    // exact tiny results raise inexact only through overflow
    if (op_req.tiny) begin
      exc[`EXC_INEXACT] = op_req.overflow | inexact_tiny
                        | (inexact_raw & s_q.trap_mask[`EXC_UNDER]);  // RULE22
    end else begin
      exc[`EXC_INEXACT] = op_req.overflow | inexact_raw;  // RULE12 RULE19
    end
    hit = exc & s_q.trap_mask;                         // RULE9
  end

  // next state
  always_comb begin
    s_d            = s_q;
    s_d.rsp.done   = 1'b0;
    s_d.rsp.trap   = 1'b0;
    s_d.rsp.dest_we = 1'b0;
    s_d.rsp.fcc_we = 1'b0;
    s_d.rdata      = 32'h0000_0000;

    // register reads, data stands one cycle
    if (reg_rd) begin
      case (reg_addr)
        `OFS_STATE: begin
          s_d.rdata[`CEXC_LSB +: 5]  = s_q.cexc;
          s_d.rdata[`AEXC_LSB +: 5]  = s_q.aexc;
          s_d.rdata[`TTYPE_LSB +: 3] = s_q.ttype;
          s_d.rdata[`MASK_LSB +: 5]  = s_q.trap_mask;
        end
        `OFS_CTRL: begin
          s_d.rdata[`CTRL_EN_BIT] = s_q.en;
        end
        default: begin
          s_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // register writes
    if (reg_wr) begin
      case (reg_addr)
        `OFS_STATE: begin
          s_d.cexc = reg_wdata[`CEXC_LSB +: 5];
          s_d.aexc = reg_wdata[`AEXC_LSB +: 5];
          s_d.trap_mask = reg_wdata[`MASK_LSB +: 5];
        end
        `OFS_CTRL: begin
          s_d.en = reg_wdata[`CTRL_EN_BIT];
        end
        default: begin
          s_d.en = s_q.en;
        end
      endcase
    end

    // operation outcome, highest priority first
    if (op_req.valid) begin
      s_d.rsp.done = 1'b1;
      s_d.rsp.pc   = op_req.pc;                        // RULE5
      s_d.rsp.sel  = fp_trap_pkg::RES_COMPUTED;
      if (!s_q.en) begin                               // RULE8
        s_d.rsp.trap   = 1'b1;                         // RULE1
        s_d.rsp.vector = `VEC_FPU_OFF;                 // RULE2
      end else if (op_req.not_provided | op_req.not_completed) begin
        s_d.rsp.trap   = 1'b1;                         // RULE3
        s_d.rsp.vector = `VEC_INCOMPLETE;
        s_d.ttype      = op_req.not_provided ?
                         `TTYPE_NOT_PROV : `TTYPE_NOT_DONE;    // RULE4
      end else if (|hit) begin
        s_d.rsp.trap   = 1'b1;                         // RULE6 RULE17
        s_d.rsp.vector = `VEC_IEEE;
        s_d.ttype      = `TTYPE_IEEE;                  // RULE4
        s_d.cexc       = s_d.cexc | hit;               // RULE7
      end else begin
        // untrapped: flags and default result
        s_d.cexc        = s_d.cexc | exc;              // RULE10
        s_d.aexc        = s_d.aexc | exc;              // RULE19
        s_d.rsp.dest_we = 1'b1;
        s_d.rsp.fcc_we  = 1'b1;
        if (op_req.overflow && !exc[`EXC_BADOP]) begin
          s_d.rsp.sel = fp_trap_pkg::RES_INFINITY;     // RULE13
        end else if (op_req.gross_uf) begin
          s_d.rsp.sel = fp_trap_pkg::RES_ZERO;         // RULE15 RULE16
        end
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk or negedge rst_n_q) begin
    if (!rst_n_q) begin
      s_q       <= '0;
      s_q.trap_mask <= `MASK_RST;
      s_q.en    <= `EN_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from flops
  assign reg_rdata = s_q.rdata;
  assign op_rsp    = s_q.rsp;

endmodule : fp_trap_exception_unit

// ===== fp_trap_cfg.svh
// Purpose : constants for the fp trap and exception unit
// Assumes : included by bare name
// Notes   : offsets are byte addresses on the register port
`ifndef FP_TRAP_CFG_SVH
`define FP_TRAP_CFG_SVH

// ==========================================================
// register offsets
`define ADDR_W          8
`define OFS_STATE       8'h00
`define OFS_CTRL        8'h04

// ==========================================================
// state and control register field positions
`define CEXC_LSB        0
`define AEXC_LSB        5
`define TTYPE_LSB       14
`define MASK_LSB        23
`define CTRL_EN_BIT     0

// ==========================================================
// exception bit order inside a 5-bit group
`define EXC_INEXACT     0
`define EXC_DIVZERO     1
`define EXC_UNDER       2
`define EXC_OVER        3
`define EXC_BADOP       4

// ==========================================================
// trap vectors and trap type codes
`define VEC_FPU_OFF     9'h020
`define VEC_IEEE        9'h021
`define VEC_INCOMPLETE  9'h022
`define TTYPE_IEEE      3'h1
`define TTYPE_NOT_DONE  3'h2
`define TTYPE_NOT_PROV  3'h3

// ==========================================================
// reset values
`define MASK_RST        5'h00
`define EN_RST          1'h0

`endif

// ===== fp_trap_pkg.sv
// Purpose : types for the fp trap and exception unit
// Assumes : nothing
// Notes   : groups run bad op, overflow, underflow, div zero, inexact high to low
package fp_trap_pkg;

  // ========================================================
  // default result chosen for the destination register
  typedef enum logic [1:0] {
    RES_COMPUTED = 2'b00,
    RES_INFINITY = 2'b01,
    RES_ZERO     = 2'b10
  } res_sel_t;

  // ========================================================
  // one finished operation from the datapath
  typedef struct packed {
    logic        valid;
    logic [63:0] pc;
    logic        not_completed;
    logic        not_provided;
    logic        is_divide;
    logic        divisor_zero;
    logic        nan_source;
    logic        int_no_fit;
    logic        overflow;
    logic        tiny;
    logic        inexact;
    logic        r_subnormal;
    logic        gross_uf;
  } op_req_t;

  // ========================================================
  // answer to the pipeline
  typedef struct packed {
    logic        done;
    logic        dest_we;
    logic        fcc_we;
    res_sel_t    sel;
    logic        trap;
    logic [8:0]  vector;
    logic [63:0] pc;
  } op_rsp_t;

  // ========================================================
  // all state of the unit
  typedef struct packed {
    logic [4:0]  cexc;
    logic [4:0]  aexc;
    logic [4:0]  trap_mask;
    logic [2:0]  ttype;
    logic        en;
    op_rsp_t     rsp;
    logic [31:0] rdata;
  } state_t;

endpackage : fp_trap_pkg

// ===== fp_trap_sva.sv
// Purpose: op port checks for the fp trap unit
// Assumes: bound to the unit top
// Notes: flags are seen only through answers
`timescale 1ns/100ps
module fp_trap_sva (
  // clock and reset
  input wire logic                 sys_clk,
  input wire logic                 arst_n,
  // op port
  input wire fp_trap_pkg::op_req_t op_req,
  input wire fp_trap_pkg::op_rsp_t op_rsp
);
  // ==========================================
  // answer timing and trap routing
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  AST_ANSWER: assert property (op_req.valid |=> op_rsp.done)
    else $error("op not answered");
  AST_IDLE: assert property (!op_req.valid |=> !op_rsp.done)
    else $error("answer without op");
  AST_INCOMPL: assert property (
    op_req.valid && (op_req.not_completed || op_req.not_provided)
    |=> op_rsp.trap && op_rsp.vector inside {9'h020, 9'h022})
    else $error("incomplete op not trapped");
  AST_PC: assert property (
    op_req.valid |=> !op_rsp.trap || op_rsp.pc == $past(op_req.pc))
    else $error("trap pc wrong");
  AST_ONE_WAY: assert property (op_rsp.done |-> op_rsp.trap != op_rsp.dest_we)
    else $error("trap and write together");
  AST_FCC: assert property (op_rsp.done |-> op_rsp.fcc_we == op_rsp.dest_we)
    else $error("fcc write mismatch");
  AST_INF: assert property (
    op_req.valid && op_req.overflow && !op_req.nan_source && !op_req.int_no_fit
    |=> op_rsp.trap || op_rsp.sel == fp_trap_pkg::RES_INFINITY)
    else $error("overflow result not infinity");
  AST_ZERO: assert property (
    op_req.valid && op_req.gross_uf && !op_req.overflow
    |=> op_rsp.trap || op_rsp.sel == fp_trap_pkg::RES_ZERO)
    else $error("gross underflow not zero");
  AST_QUIET: assert property (
    op_req.valid && op_req[10:0] inside {11'h000, 11'h080}
    |=> !op_rsp.trap || op_rsp.vector == 9'h020)
    else $error("trap without cause");
  // main scenarios reached
  cover property (op_rsp.trap && op_rsp.vector == 9'h020);
  cover property (op_rsp.trap && op_rsp.vector == 9'h021);
  cover property (op_rsp.trap && op_rsp.vector == 9'h022);
endmodule : fp_trap_sva
bind fp_trap_exception_unit fp_trap_sva chk_u (.sys_clk, .arst_n, .op_req, .op_rsp);

// ===== fp_pipe_model.sv
// Purpose: pipeline side of the op port
// Assumes: one op per go pulse
// Notes: idle op fields toggle every cycle
`timescale 1ns/100ps
module fp_pipe_model (
  // clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 arst_n,
  // bench side
  input  wire logic                 go,
  input  wire fp_trap_pkg::op_req_t req,
  output logic                      seen,
  output fp_trap_pkg::op_rsp_t      got,
  // unit side
  output fp_trap_pkg::op_req_t      op_req,
  input  wire fp_trap_pkg::op_rsp_t op_rsp
);
  // issue op, capture its answer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      op_req <= '0;
      seen   <= 1'b0;
      got    <= '0;
    end else begin
      op_req <= go ? req : {1'b0, ~op_req[$bits(op_req)-2:0]};
      if (go) begin
        seen <= 1'b0;
      end else if (op_rsp.done) begin
        seen <= 1'b1;
        got  <= op_rsp;
      end
    end
  end
endmodule : fp_pipe_model

// ===== fp_trap_exception_unit_bench.sv
// Purpose: self-checking bench for the fp trap unit
// Assumes: state word at 00, enable at 04
// Notes: flags bad op, overflow, underflow, div zero, inexact high to low
`timescale 1ns/100ps
module fp_trap_exception_unit_bench;
  logic                 sys_clk = 1'b0;
  logic                 arst_n = 1'b1;
  logic [7:0]           reg_addr = 8'h00;
  logic [31:0]          reg_wdata = 32'h0, reg_rdata;
  logic                 reg_wr = 1'b0, reg_rd = 1'b0, pm_go = 1'b0, pm_seen;
  fp_trap_pkg::op_req_t op_req, pm_req = '0;
  fp_trap_pkg::op_rsp_t op_rsp, pm_got;
  int                   n_mismatch = 0, checks_done = 0;
  always #5 sys_clk = ~sys_clk;
  fp_trap_exception_unit dut_u (.sys_clk, .arst_n, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .op_req, .op_rsp);
  fp_pipe_model pm_u (.sys_clk, .arst_n, .go(pm_go), .req(pm_req), .seen(pm_seen),
    .got(pm_got), .op_req, .op_rsp);
  // ==========================================
  // bus and compare helpers
  task automatic chk(string n, logic [63:0] e, logic [63:0] s);
    checks_done++;
    if (s !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    @(posedge sys_clk);
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 chk("reg_rdata", e, reg_rdata);
    @(posedge sys_clk);
  endtask : rd
  // one op under mask m; v is vector on trap, else sel
  task automatic run(logic [10:0] f, logic [4:0] m, logic tr, logic [8:0] v, logic [31:0] e);
    wr(8'h00, {4'h0, m, 23'h0});
    pm_req <= {1'b1, 64'h1, f};
    pm_go  <= 1'b1;
    @(posedge sys_clk);
    pm_go <= 1'b0;
    #1;
    for (int i = 0; i < 6 && !pm_seen; i++) begin
      @(posedge sys_clk);
      #1;
    end
    chk("done", 1'b1, pm_seen);
    chk("trap", tr, pm_got.trap);
    chk(tr ? "vector" : "sel", tr ? v : v[1:0], tr ? pm_got.vector : pm_got.sel);
    if (tr) chk("pc", 64'h1, pm_got.pc);
    rd(8'h00, e);
  endtask : run
  // ==========================================
  // scenarios
  task automatic t_regs;
    rd(8'h04, 32'h0);
    rd(8'h08, 32'h0);
    wr(8'h00, 32'h0f800000);
    rd(8'h00, 32'h0f800000);
    $display("regs done");
  endtask : t_regs
  task automatic t_trap;
    run(11'h240, 5'h10, 1'b1, 9'h020, 32'h08000000);
    wr(8'h04, 32'h1);
    run(11'h200, 5'h00, 1'b1, 9'h022, 32'h0000c000);
    run(11'h450, 5'h18, 1'b1, 9'h022, 32'h0c008000);
    run(11'h040, 5'h10, 1'b1, 9'h021, 32'h08004010);
    run(11'h020, 5'h10, 1'b1, 9'h021, 32'h08004010);
    run(11'h010, 5'h08, 1'b1, 9'h021, 32'h04004008);
    $display("trap done");
  endtask : t_trap
  task automatic t_mask;
    run(11'h010, 5'h00, 1'b0, 9'h001, 32'h00004129);
    run(11'h001, 5'h00, 1'b0, 9'h002, 32'h00004021);
    run(11'h080, 5'h02, 1'b0, 9'h000, 32'h01004000);
    run(11'h180, 5'h00, 1'b0, 9'h000, 32'h00004042);
    $display("mask done");
  endtask : t_mask
  task automatic t_uf;
    run(11'h00a, 5'h00, 1'b0, 9'h000, 32'h00004000);
    run(11'h00c, 5'h00, 1'b0, 9'h000, 32'h00004084);
    run(11'h00c, 5'h01, 1'b1, 9'h021, 32'h00804001);
    run(11'h00a, 5'h04, 1'b1, 9'h021, 32'h02004004);
    run(11'h008, 5'h04, 1'b0, 9'h000, 32'h02004000);
    $display("uf done");
  endtask : t_uf
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  // main sequence
  initial begin
    arst_n <= 1'b0;
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    t_regs;
    t_trap;
    t_mask;
    t_uf;
    close_out;
  end
  // watchdog
  initial begin
    #100000;
    n_mismatch++;
    close_out;
  end
endmodule : fp_trap_exception_unit_bench
